//--- verilog/pbctl_pkg.sv
// Function
// - Latched output turns on only after closure lasts longer than debounce period.
// - Debounce period is a build option: 50 ms short or 2 s long.
// - Long-press variant turns latched output off after closure exceeds shutdown period.
// - Shutdown period is a build option: 8 s or 16 s.
// - Variant without long-press shutdown never turns output off from a closure.
// - Variant without long-press shutdown stretches interrupt while closure continues.
// - One interrupt pulse per debounced closure, nominally 32 ms wide.
// - Active-low clear forces latched output off asynchronously, without timebase tick.
package pbctl_pkg;

  // Timebase
  localparam int CLK_MHZ          = 50;
  localparam int TICK_US          = 1000;
  localparam int TICK_CYCLES_DEF  = TICK_US * CLK_MHZ;

  // Durations in milliseconds
  localparam int DEB_SHORT_MS     = 50;
  localparam int DEB_LONG_MS      = 2000;
  localparam int SD_SHORT_MS      = 8000;
  localparam int SD_LONG_MS       = 16000;
  localparam int INT_MS           = 32;

  // Durations in timebase ticks
  localparam int TICK_PER_MS      = 1000 / TICK_US;
  localparam int DEB_SHORT_TICKS  = DEB_SHORT_MS * TICK_PER_MS;
  localparam int DEB_LONG_TICKS   = DEB_LONG_MS * TICK_PER_MS;
  localparam int SD_SHORT_TICKS   = SD_SHORT_MS * TICK_PER_MS;
  localparam int SD_LONG_TICKS    = SD_LONG_MS * TICK_PER_MS;
  localparam int INT_TICKS        = INT_MS * TICK_PER_MS;

  // Counter widths
  localparam int PRESS_W          = 15;
  localparam int INT_W            = 6;

  // Reset values
  localparam logic RST_ON         = 1'b0;
  localparam logic RST_INT        = 1'b0;

  typedef enum logic [2:0] {
    PBCTL_IDLE     = 3'b001,
    PBCTL_DEBOUNCE = 3'b010,
    PBCTL_HELD     = 3'b100
  } pbctl_state_type;

  typedef struct packed {
    logic on;
    logic intr;
  } pbctl_out_type;

  function automatic logic [PRESS_W-1:0] pbctl_pick(input logic sel_long,
                                                    input int   short_t,
                                                    input int   long_t);
    pbctl_pick = sel_long ? PRESS_W'(long_t) : PRESS_W'(short_t);
  endfunction

endpackage

//--- verilog/pbctl_sync.sv
`timescale 1ns/1ps
module pbctl_sync import pbctl_pkg::*; (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pin_n_i,
  output logic      pressed_o
);

  logic meta_r;
  logic sync_r;

  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= pin_n_i;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pressed_o <= 1'b0;
    end else begin
      pressed_o <= ~sync_r;
    end
  end

endmodule // pbctl_sync

//--- verilog/pbctl_top.sv
`timescale 1ns/1ps
module pbctl_top import pbctl_pkg::*; #(
  parameter int   TICK_CYCLES   = TICK_CYCLES_DEF,
  parameter logic LONG_DEBOUNCE = 1'b0,
  parameter logic LONG_SHUTDOWN = 1'b0,
  parameter logic LONG_PRESS_OFF = 1'b1
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic pushbutton_in_n_i,
  input  wire logic force_off_in_n_i,
  output logic      on_o,
  output logic      int_o
);

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // Closure length windows in clocks, for the checks only
  localparam int          DEB_EXP = LONG_DEBOUNCE ? DEB_LONG_TICKS : DEB_SHORT_TICKS;
  localparam int          SD_EXP  = LONG_SHUTDOWN ? SD_LONG_TICKS : SD_SHORT_TICKS;
  localparam logic [31:0] DEB_LO  = 32'(DEB_EXP * TICK_CYCLES);
  localparam logic [31:0] DEB_HI  = 32'((DEB_EXP + 1) * TICK_CYCLES);
  localparam logic [31:0] SD_LO   = 32'(SD_EXP * TICK_CYCLES);
  localparam logic [31:0] SD_HI   = 32'((SD_EXP + 1) * TICK_CYCLES);

  logic                 pressed;
  logic [TW-1:0]        tick_cnt_r;
  logic                 tick_r;
  logic [PRESS_W-1:0]   press_cnt_r;
  logic [PRESS_W-1:0]   deb_ticks;
  logic [PRESS_W-1:0]   sd_ticks;
  logic [INT_W-1:0]     int_cnt_r;
  pbctl_state_type      state_r;
  pbctl_state_type      state_nxt;
  pbctl_out_type        out_r;
  logic [31:0]          held_cyc_r;
  logic                 deb_evt;
  logic                 sd_evt;

  assign deb_ticks = pbctl_pick(LONG_DEBOUNCE, DEB_SHORT_TICKS, DEB_LONG_TICKS);
  assign sd_ticks  = pbctl_pick(LONG_SHUTDOWN, SD_SHORT_TICKS, SD_LONG_TICKS);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  pbctl_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .pin_n_i   (pushbutton_in_n_i),
    .pressed_o (pressed)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Timebase

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Closure length counter

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      press_cnt_r <= '0;
    end else if (!pressed) begin
      press_cnt_r <= '0;
    end else if (tick_r && press_cnt_r <= sd_ticks) begin
      press_cnt_r <= press_cnt_r + 1'b1;
    end
  end

  // Events fire once when the count first passes the threshold
  assign deb_evt = pressed && tick_r && (press_cnt_r == deb_ticks) &&
                   (state_r == PBCTL_DEBOUNCE);
  assign sd_evt  = pressed && tick_r && (press_cnt_r == sd_ticks) &&
                   (state_r == PBCTL_HELD);

  //////////////////////////////////////////////////////////////////////////////
  // Check helper: clocks of the current closure, apart from the timebase

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !pressed) begin
      held_cyc_r <= '0;
    end else if (held_cyc_r != '1) begin
      held_cyc_r <= held_cyc_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Closure state machine

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PBCTL_IDLE: begin
        if (pressed) begin
          state_nxt = PBCTL_DEBOUNCE;
        end
      end
      PBCTL_DEBOUNCE: begin
        if (!pressed) begin
          state_nxt = PBCTL_IDLE;
        end else if (deb_evt) begin
          state_nxt = PBCTL_HELD;
        end
      end
      PBCTL_HELD: begin
        if (!pressed) begin
          state_nxt = PBCTL_IDLE;
        end
      end
      default: state_nxt = PBCTL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_r <= PBCTL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latched output; clear acts without the clock

  always_ff @(posedge sys_clk_i or negedge force_off_in_n_i) begin
    if (!force_off_in_n_i) begin
      out_r.on <= 1'b0;
    end else if (rst_i) begin
      out_r.on <= RST_ON;
    end else if (sd_evt && LONG_PRESS_OFF) begin
      out_r.on <= 1'b0;
    end else if (deb_evt) begin
      out_r.on <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt one-shot

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_cnt_r <= '0;
      out_r.intr <= RST_INT;
    end else if (deb_evt) begin
      int_cnt_r  <= INT_W'(INT_TICKS);
      out_r.intr <= 1'b1;
    end else if (!LONG_PRESS_OFF && pressed && state_r == PBCTL_HELD) begin
      int_cnt_r  <= INT_W'(INT_TICKS);
      out_r.intr <= 1'b1;
    end else if (tick_r && int_cnt_r != '0) begin
      int_cnt_r  <= int_cnt_r - 1'b1;
      out_r.intr <= (int_cnt_r != INT_W'(1));
    end
  end

  assign on_o  = out_r.on;
  assign int_o = out_r.intr;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_on_after_debounce: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(on_o) |-> $past(press_cnt_r) == deb_ticks && $past(pressed))
    else $error("Output turned on without full debounce");

  chk_debounce_option: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(on_o) |-> held_cyc_r > DEB_LO && held_cyc_r <= DEB_HI)
    else $error("Debounce period not the selected option");

  chk_long_press_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (sd_evt && LONG_PRESS_OFF) |=> !on_o)
    else $error("Long press did not turn output off");

  chk_shutdown_option: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ($fell(on_o) && force_off_in_n_i && $past(force_off_in_n_i)) |->
    held_cyc_r > SD_LO && held_cyc_r <= SD_HI)
    else $error("Shutdown period not the selected option");

  chk_no_press_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!LONG_PRESS_OFF && $past(force_off_in_n_i) && force_off_in_n_i) |-> !$fell(on_o))
    else $error("Output turned off by a closure");

  chk_int_stretch: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!LONG_PRESS_OFF && state_r == PBCTL_HELD && pressed) |=> int_o)
    else $error("Interrupt not held during long closure");

  chk_int_one_shot: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $rose(int_o) |-> $past(deb_evt) && int_cnt_r == INT_W'(INT_TICKS))
    else $error("Interrupt start without a debounced closure");

  chk_clear_forces: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !force_off_in_n_i |-> !on_o)
    else $error("Output on while clear held");

  chk_release_keeps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (state_r == PBCTL_DEBOUNCE && !pressed) |=> $stable(int_o) && state_r == PBCTL_IDLE)
    else $error("Early release changed outputs");

  chk_release_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !pressed |=> press_cnt_r == '0)
    else $error("Closure counter not reset on release");

  chk_tick_phase: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    tick_r |-> tick_cnt_r == '0)
    else $error("Timebase tick off its phase");

  cov_turn_on:   cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(on_o));
  cov_long_off:  cover property (@(posedge sys_clk_i) disable iff (rst_i) sd_evt);
  cov_clear:     cover property (@(posedge sys_clk_i) disable iff (rst_i)
    $fell(on_o) && !force_off_in_n_i);
  cov_stretch:   cover property (@(posedge sys_clk_i) disable iff (rst_i)
    !LONG_PRESS_OFF && state_r == PBCTL_HELD && pressed);
  cov_bounce:    cover property (@(posedge sys_clk_i) disable iff (rst_i)
    state_r == PBCTL_DEBOUNCE && !pressed);

endmodule // pbctl_top

//--- dv/pbctl_button.sv
`timescale 1ns/1ps
module pbctl_button (
  input  wire logic sys_clk_i,
  input  wire logic press_i,
  output logic      pin_n_o
);
  logic       last_r;
  logic [3:0] bounce_r;
  initial begin
    pin_n_o  = 1'b1;
    last_r   = 1'b0;
    bounce_r = 4'h0;
  end
  // Contacts chatter on every change; open contact pulled high
  always @(negedge sys_clk_i) begin
    if (press_i != last_r) begin
      last_r   <= press_i;
      bounce_r <= 4'h7;
    end else if (bounce_r != 4'h0) begin
      bounce_r <= bounce_r - 4'h1;
    end
    pin_n_o <= (bounce_r != 4'h0) ? ~pin_n_o : ~last_r;
  end
endmodule // pbctl_button

//--- dv/test_pbctl_top.sv
`timescale 1ns/1ps
module test_pbctl_top import pbctl_pkg::*; ;
  localparam int TK   = 4;
  localparam int DEB  = DEB_SHORT_TICKS * TK;
  localparam int SD   = SD_SHORT_TICKS * TK;
  localparam int INTC = INT_TICKS * TK;
  logic clk, rst, force_n, press, pin_n, on_a, int_a, on_b, int_b, on_c;
  int   bad_count, n_compared;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  pbctl_button btn (.sys_clk_i(clk), .press_i(press), .pin_n_o(pin_n));
  pbctl_top #(.TICK_CYCLES(TK), .LONG_PRESS_OFF(1'b1)) dut (.sys_clk_i(clk), .rst_i(rst),
    .pushbutton_in_n_i(pin_n), .force_off_in_n_i(force_n), .on_o(on_a), .int_o(int_a));
  pbctl_top #(.TICK_CYCLES(TK), .LONG_PRESS_OFF(1'b0)) dut_b (.sys_clk_i(clk), .rst_i(rst),
    .pushbutton_in_n_i(pin_n), .force_off_in_n_i(force_n), .on_o(on_b), .int_o(int_b));
  pbctl_top #(.TICK_CYCLES(1), .LONG_DEBOUNCE(1'b1), .LONG_SHUTDOWN(1'b1)) dut_c (
    .sys_clk_i(clk), .rst_i(rst), .pushbutton_in_n_i(pin_n), .force_off_in_n_i(force_n),
    .on_o(on_c), .int_o());
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic seen, input logic exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_on(input int lim);
    for (int i = 0; i < lim && on_a !== 1'b1; i++) cyc(1);
    if (on_a !== 1'b1) begin
      check("on_a rise", on_a, 1'b1);
      results();
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic s_short;
    press <= 1'b1;
    cyc(DEB - 20);
    press <= 1'b0;
    cyc(30);
    check("on_a", on_a, 1'b0);
    check("int_a", int_a, 1'b0);
    check("on_b", on_b, 1'b0);
  endtask
  task automatic s_press;
    int n;
    press <= 1'b1;
    cyc(DEB);
    check("on_a early", on_a, 1'b0);
    wait_on(40);
    check("int_a", int_a, 1'b1);
    check("on_b", on_b, 1'b1);
    press <= 1'b0;
    for (n = 0; n < INTC + 40 && int_a === 1'b1; n++) cyc(1);
    check("int_a width", n >= INTC - 8 && n <= INTC + 8, 1'b1);
  endtask
  task automatic s_clear;
    force_n <= 1'b0;
    #2;
    check("on_a cleared", on_a, 1'b0);
    check("on_b cleared", on_b, 1'b0);
    cyc(1);
    force_n <= 1'b1;
    cyc(INTC + 40);
  endtask
  task automatic s_long;
    press <= 1'b1;
    wait_on(DEB + 60);
    cyc(DEB_LONG_TICKS - DEB - 100);
    check("on_c early", on_c, 1'b0);
    cyc(200);
    check("on_c on", on_c, 1'b1);
    cyc(SD_LONG_TICKS - DEB_LONG_TICKS - 200);
    check("on_c held", on_c, 1'b1);
    cyc(200);
    check("on_c long off", on_c, 1'b0);
    cyc(SD - SD_LONG_TICKS - 200);
    check("on_a held", on_a, 1'b1);
    for (int i = 0; i < 200 && on_a === 1'b1; i++) cyc(1);
    check("on_a long off", on_a, 1'b0);
    check("on_b long", on_b, 1'b1);
    check("int_b held", int_b, 1'b1);
    press <= 1'b0;
    cyc(INTC - 20);
    check("int_b tail", int_b, 1'b1);
    cyc(40);
    check("int_b end", int_b, 1'b0);
    check("on_b kept", on_b, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    bad_count  = 0;
    n_compared = 0;
    rst        = 1'b1;
    force_n    = 1'b1;
    press      = 1'b0;
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    check("on_a reset", on_a, 1'b0);
    check("int_a reset", int_a, 1'b0);
    s_short();
    s_press();
    s_clear();
    s_long();
    results();
  end
endmodule // test_pbctl_top
